// [rtl/fts_chan_if.sv]
// signals between the register block and one tachometer channel
`timescale 1ns/10ps
interface fts_chan_if;
    logic       enable;
    logic [1:0] div_sel;
    logic       tick;
    logic       clear;
    logic [7:0] count;
    logic       rev_done;
    logic [7:0] rev_count;
    logic       saturated;

    modport top  (output enable, div_sel, tick, clear,
                  input  count, rev_done, rev_count, saturated);
    modport chan (input  enable, div_sel, tick, clear,
                  output count, rev_done, rev_count, saturated);
endinterface : fts_chan_if

// [rtl/fts_channel.sv]
// one tachometer channel: synchroniser, edge filter, revolution counter
`timescale 1ns/10ps
`include "fts_regs.svh"
module fts_channel
    import fts_pkg::*;
#(
    parameter int FILT_CYC = `FTS_FILT_CYC
) (
    input  wire logic  i_mclk,
    input  wire logic  i_rst_n,
    input  wire logic  i_pin,
    fts_chan_if.chan   bus
);

    typedef struct packed {
        logic              sync1;
        logic              sync2;
        logic              filt;
        logic [7:0]        fcnt;
        logic [2:0]        pre;
        logic [7:0]        cnt;
        fts_rev_state_type state;
        logic              rev_done;
        logic [7:0]        rev_cnt;
        logic              sat_hit;
    } fts_chan_state_type;

    fts_chan_state_type s_ff;
    fts_chan_state_type nxt_s;
    logic               edge_seen;

    always_comb begin
        nxt_s = s_ff;
        edge_seen = 1'b0;
        nxt_s.sync1 = i_pin;
        nxt_s.sync2 = s_ff.sync1;
        // a level must hold for the whole window; slow tach edges chatter [R06]
        if (s_ff.sync2 != s_ff.filt) begin
            if (s_ff.fcnt == 8'(FILT_CYC - 1)) begin
                nxt_s.filt = s_ff.sync2;
                nxt_s.fcnt = 8'h00;
                edge_seen  = s_ff.sync2;
            end else begin
                nxt_s.fcnt = 8'(s_ff.fcnt + 8'h01);
            end
        end else begin
            nxt_s.fcnt = 8'h00;
        end
        nxt_s.rev_done = 1'b0;
        nxt_s.sat_hit  = 1'b0;
        if (!bus.enable || bus.clear) begin
            nxt_s.state = FTS_WAIT_FIRST;
            nxt_s.cnt   = `FTS_COUNT_RESET;
            nxt_s.pre   = 3'h0;
        end else begin
            // divisor prescales the 20 kHz tick [R04] [R05] [R19]
            if (bus.tick) begin
                if (s_ff.pre >= fts_div_max(bus.div_sel)) begin
                    nxt_s.pre = 3'h0;
                    if (s_ff.cnt != `FTS_COUNT_MAX) begin
                        nxt_s.cnt = 8'(s_ff.cnt + 8'h01);
                    end
                    nxt_s.sat_hit = (s_ff.cnt == `FTS_COUNT_NEAR_MAX); // [R18]
                end else begin
                    nxt_s.pre = 3'(s_ff.pre + 3'h1);
                end
            end
            // two tach pulses make one revolution [R16]
            if (edge_seen) begin
                unique case (s_ff.state)
                    FTS_WAIT_FIRST: begin
                        nxt_s.state = FTS_HALF_REV;
                        nxt_s.cnt   = `FTS_COUNT_RESET;
                        nxt_s.pre   = 3'h0;
                    end
                    FTS_HALF_REV: begin
                        nxt_s.state = FTS_FULL_REV;
                    end
                    FTS_FULL_REV: begin
                        nxt_s.state    = FTS_HALF_REV;
                        nxt_s.rev_done = 1'b1;
                        nxt_s.rev_cnt  = s_ff.cnt;
                        nxt_s.cnt      = `FTS_COUNT_RESET;
                        nxt_s.pre      = 3'h0;
                    end
                    default: begin
                        nxt_s.state = FTS_WAIT_FIRST;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign bus.count     = s_ff.cnt;
    assign bus.rev_done  = s_ff.rev_done;
    assign bus.rev_count = s_ff.rev_cnt;
    assign bus.saturated = s_ff.sat_hit;

    a_count_saturates: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [R18]
        s_ff.cnt == `FTS_COUNT_MAX && bus.enable && !bus.clear && !edge_seen
        |=> s_ff.cnt == `FTS_COUNT_MAX)
        else $error("tach counter wrapped");
    a_rev_two_edges: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [R13]
        s_ff.rev_done |-> $past(s_ff.state) == FTS_FULL_REV)
        else $error("revolution done without two edges");

endmodule : fts_channel

// [rtl/fts_pkg.sv]
// shared types of the fan monitor
package fts_pkg;

    typedef enum logic [1:0] {
        FTS_WAIT_FIRST = 2'b00,
        FTS_HALF_REV   = 2'b01,
        FTS_FULL_REV   = 2'b10
    } fts_rev_state_type;

    typedef logic [7:0] fts_byte_type;

    // divisor code to prescale terminal value (1, 2, 4, 8 ticks per count)
    function automatic logic [2:0] fts_div_max(input logic [1:0] sel);
        unique case (sel)
            2'b00: fts_div_max = 3'h0;
            2'b01: fts_div_max = 3'h1;
            2'b10: fts_div_max = 3'h3;
            2'b11: fts_div_max = 3'h7;
        endcase
    endfunction : fts_div_max

endpackage : fts_pkg

// [rtl/fts_regs.svh]
// register offsets, field positions, reset values and timing counts of the fan monitor
`ifndef FTS_REGS_SVH
`define FTS_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FTS_ADDR_CTRL0      8'h30
`define FTS_ADDR_LIMIT0     8'h31
`define FTS_ADDR_COUNT0     8'h32
`define FTS_ADDR_CTRL1      8'h34
`define FTS_ADDR_LIMIT1     8'h35
`define FTS_ADDR_COUNT1     8'h36

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define FTS_EN_BIT          7
`define FTS_IE_BIT          6
`define FTS_DIV_MSB         1
`define FTS_DIV_LSB         0
`define FTS_CTRL_WMASK      8'hC3
`define FTS_CTRL_RESET      8'h00
`define FTS_LIMIT_RESET     8'h00
`define FTS_COUNT_RESET     8'h00
`define FTS_COUNT_MAX       8'hFF
`define FTS_COUNT_NEAR_MAX  8'hFE

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FTS_CLK_HZ          200000000
`define FTS_TICK_HZ         20000
`define FTS_CLK_NS          5
`define FTS_FILT_NS         1000
`define FTS_FILT_CYC        ((`FTS_FILT_NS + `FTS_CLK_NS - 1) / `FTS_CLK_NS)

`endif

// [rtl/fts_top.sv]
// fan tachometer speed monitor: registers, tick divider, alarm and pin steering
//
// What this block does
// R01: enable bit makes pin a tach input
// R02: bypass select drives odd pins as outputs
// R03: disabled channel ignores alarm and divisor
// R04: tach pulses gate 20 kHz tick counter
// R05: divisor code selects 1, 2, 4, 8
// R06: filter slow tach edges into clean pulses
// R07: alarm when enabled and count reaches limit
// R08: source code holds offending control address
// R09: eight-bit limit register, reset zero
// R10: software loads limit before enabling channel
// R11: count reads zero before first revolution
// R12: stalled fan reads all ones
// R13: polled mode refreshes count each revolution
// R14: alarm holds count until cleared
// R15: clearing alarm zeroes current count
// R16: count equals 1200000 over rpm times divisor
// R17: channel one mirrors channel zero
// R18: counter saturates instead of wrapping
// R19: divisor prescales the gating tick
// R20: reserved control bits read zero
`timescale 1ns/10ps
`include "fts_regs.svh"
module fts_top
    import fts_pkg::*;
#(
    parameter int TICK_DIV = `FTS_CLK_HZ / `FTS_TICK_HZ,
    parameter int FILT_CYC = `FTS_FILT_CYC
) (
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_rd,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_irq_clear,
    output logic            o_int_n,
    output logic      [7:0] o_interrupt_source_code,
    input  wire logic [1:0] i_gpio_out,
    input  wire logic [1:0] i_gpio_oe,
    input  wire logic       i_bypass_sel_1,
    input  wire logic       i_bypass_out_1,
    input  wire logic       i_fan_tach_pin_0,
    output logic            o_fan_tach_pin_0,
    output logic            o_fan_tach_pin_0_oe,
    input  wire logic       i_fan_tach_pin_1,
    output logic            o_fan_tach_pin_1,
    output logic            o_fan_tach_pin_1_oe
);

    // ----------------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]      tick_cnt;
        logic             tick;
        logic [1:0][7:0]  ctrl;
        logic [1:0][7:0]  limit;
        logic [1:0][7:0]  cur;
        logic             pend;
        logic             src_ch;
        logic [7:0]       src_code;
        logic [7:0]       rdata;
        logic [1:0]       pin_out;
        logic [1:0]       pin_oe;
    } fts_top_state_type;

    fts_top_state_type s_ff;
    fts_top_state_type nxt_s;

    fts_chan_if ch_if [2] ();

    logic [1:0]      clr_ch;
    logic [1:0]      alarm;
    logic [1:0]      ch_en;
    logic [1:0]      ch_ie;
    logic [1:0][7:0] ch_count;
    logic [1:0][7:0] ch_rev_count;
    logic [1:0]      ch_rev_done;
    logic [1:0]      ch_sat;
    logic [1:0]      tach_pin;

    assign tach_pin = {i_fan_tach_pin_1, i_fan_tach_pin_0};

    // ----------------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign ch_if[g].enable  = s_ff.ctrl[g][`FTS_EN_BIT];
        assign ch_if[g].div_sel = s_ff.ctrl[g][`FTS_DIV_MSB:`FTS_DIV_LSB];
        assign ch_if[g].tick    = s_ff.tick;
        assign ch_if[g].clear   = clr_ch[g];
        assign ch_count[g]      = ch_if[g].count;
        assign ch_rev_count[g]  = ch_if[g].rev_count;
        assign ch_rev_done[g]   = ch_if[g].rev_done;
        assign ch_sat[g]        = ch_if[g].saturated;

        // same logic for both channels, each on its own pin [R17]
        fts_channel #(
            .FILT_CYC (FILT_CYC)
        ) u_chan (
            .i_mclk  (i_mclk),
            .i_rst_n (rst_n_ff),
            .i_pin   (tach_pin[g]),
            .bus     (ch_if[g])
        );
    end

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        // one tick every TICK_DIV core clocks gives 20 kHz [R04]
        nxt_s.tick = 1'b0;
        if (s_ff.tick_cnt == 16'(TICK_DIV - 1)) begin
            nxt_s.tick_cnt = 16'h0000;
            nxt_s.tick     = 1'b1;
        end else begin
            nxt_s.tick_cnt = 16'(s_ff.tick_cnt + 16'h0001);
        end

        // register writes; reserved bits are masked off [R09] [R20]
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `FTS_ADDR_CTRL0:  nxt_s.ctrl[0]  = i_reg_wdata & `FTS_CTRL_WMASK;
                `FTS_ADDR_LIMIT0: nxt_s.limit[0] = i_reg_wdata;
                `FTS_ADDR_CTRL1:  nxt_s.ctrl[1]  = i_reg_wdata & `FTS_CTRL_WMASK;
                `FTS_ADDR_LIMIT1: nxt_s.limit[1] = i_reg_wdata;
                default: ;
            endcase
        end

        for (int i = 0; i < 2; i++) begin
            ch_en[i]  = s_ff.ctrl[i][`FTS_EN_BIT];
            ch_ie[i]  = s_ff.ctrl[i][`FTS_IE_BIT];
            clr_ch[i] = i_irq_clear && s_ff.pend && (s_ff.src_ch == 1'(i));
            // reaches or passes; a disabled channel raises nothing [R03] [R07] [R09]
            alarm[i]  = ch_en[i] && ch_ie[i] && (ch_count[i] >= s_ff.limit[i])
                        && !clr_ch[i];
            if (!ch_en[i]) begin
                nxt_s.cur[i] = `FTS_COUNT_RESET; // [R11]
            end else if (clr_ch[i]) begin
                nxt_s.cur[i] = `FTS_COUNT_RESET; // [R15]
            end else if (s_ff.pend && (s_ff.src_ch == 1'(i))) begin
                nxt_s.cur[i] = s_ff.cur[i]; // [R14]
            end else if (ch_sat[i]) begin
                nxt_s.cur[i] = `FTS_COUNT_MAX; // [R12]
            end else if (ch_rev_done[i]) begin
                nxt_s.cur[i] = ch_rev_count[i]; // [R13]
            end
        end

        // a new alarm wins over the clear in the same cycle [R07] [R08]
        if ((!s_ff.pend || i_irq_clear) && (alarm[0] || alarm[1])) begin
            nxt_s.pend     = 1'b1;
            nxt_s.src_ch   = !alarm[0];
            nxt_s.src_code = alarm[0] ? `FTS_ADDR_CTRL0 : `FTS_ADDR_CTRL1;
        end else if (i_irq_clear) begin
            nxt_s.pend = 1'b0;
        end

        // read data, unmapped offsets answer zero
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `FTS_ADDR_CTRL0:  nxt_s.rdata = s_ff.ctrl[0]; // [R20]
                `FTS_ADDR_LIMIT0: nxt_s.rdata = s_ff.limit[0];
                `FTS_ADDR_COUNT0: nxt_s.rdata = s_ff.cur[0];
                `FTS_ADDR_CTRL1:  nxt_s.rdata = s_ff.ctrl[1];
                `FTS_ADDR_LIMIT1: nxt_s.rdata = s_ff.limit[1];
                `FTS_ADDR_COUNT1: nxt_s.rdata = s_ff.cur[1];
                default:          nxt_s.rdata = 8'h00;
            endcase
        end

        // pin steering; other configuration only when monitoring is off [R01] [R03]
        for (int i = 0; i < 2; i++) begin
            nxt_s.pin_out[i] = ch_en[i] ? 1'b0 : i_gpio_out[i];
            nxt_s.pin_oe[i]  = ch_en[i] ? 1'b0 : i_gpio_oe[i];
        end
        // bypass select survives monitor enable on the odd pin [R02]
        if (i_bypass_sel_1) begin
            nxt_s.pin_out[1] = i_bypass_out_1;
            nxt_s.pin_oe[1]  = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    assign o_reg_rdata             = s_ff.rdata;
    assign o_int_n                 = !s_ff.pend;
    assign o_interrupt_source_code = s_ff.src_code;
    assign o_fan_tach_pin_0        = s_ff.pin_out[0];
    assign o_fan_tach_pin_0_oe     = s_ff.pin_oe[0];
    assign o_fan_tach_pin_1        = s_ff.pin_out[1];
    assign o_fan_tach_pin_1_oe     = s_ff.pin_oe[1];

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n_ff);

    a_no_ie_no_int: assert property ( // [R07]
        !ch_ie[0] && !ch_ie[1] && !s_ff.pend |=> o_int_n)
        else $error("interrupt raised with alarms disabled");
    a_alarm_raises: assert property ( // [R07] [R08]
        alarm[0] && !s_ff.pend
        |=> !o_int_n && o_interrupt_source_code == `FTS_ADDR_CTRL0)
        else $error("channel zero alarm not raised");
    a_src_code_valid: assert property ( // [R08]
        !s_ff.pend ##1 s_ff.pend
        |-> o_interrupt_source_code inside {`FTS_ADDR_CTRL0, `FTS_ADDR_CTRL1})
        else $error("bad interrupt source code");
    a_pin_input_en: assert property ( // [R01]
        ch_en[0] |=> !o_fan_tach_pin_0_oe)
        else $error("enabled tach pin still driven");
    a_bypass_drive: assert property ( // [R02]
        i_bypass_sel_1 |=> o_fan_tach_pin_1_oe && o_fan_tach_pin_1 == $past(i_bypass_out_1))
        else $error("bypass output not driven");
    a_disabled_pin: assert property ( // [R03]
        !ch_en[0] |=> o_fan_tach_pin_0_oe == $past(i_gpio_oe[0]))
        else $error("disabled channel altered pin");
    a_hold_count: assert property ( // [R14]
        s_ff.pend && !s_ff.src_ch && !i_irq_clear && ch_en[0]
        && !(i_reg_wr && i_reg_addr == `FTS_ADDR_CTRL0)
        |=> s_ff.cur[0] == $past(s_ff.cur[0]))
        else $error("count moved while alarm pending");
    a_clear_zeroes: assert property ( // [R15]
        clr_ch[0] && ch_en[0] |=> s_ff.cur[0] == `FTS_COUNT_RESET)
        else $error("count not cleared with alarm");
    a_disabled_zero: assert property ( // [R11]
        !ch_en[1] |=> s_ff.cur[1] == `FTS_COUNT_RESET)
        else $error("disabled channel count not zero");
    a_reserved_zero: assert property ( // [R20]
        i_reg_rd && i_reg_addr == `FTS_ADDR_CTRL1 |=> o_reg_rdata[5:2] == 4'h0)
        else $error("reserved control bits not zero");
    a_stall_reads_ff: assert property ( // [R12]
        ch_sat[0] && ch_en[0] && !(s_ff.pend && !s_ff.src_ch) && !i_irq_clear
        |=> s_ff.cur[0] == `FTS_COUNT_MAX)
        else $error("stalled fan not reading all ones");
    a_disabled_zero_0: assert property ( // [R11] [R03]
        !ch_en[0] |=> s_ff.cur[0] == `FTS_COUNT_RESET)
        else $error("disabled channel zero count not zero");
    a_ctrl0_reserved: assert property ( // [R20]
        i_reg_rd && i_reg_addr == `FTS_ADDR_CTRL0 |=> o_reg_rdata[5:2] == 4'h0)
        else $error("reserved control zero bits not zero");
    a_int_holds: assert property ( // [R14]
        !o_int_n && !i_irq_clear |=> !o_int_n)
        else $error("interrupt dropped without a clear");
    a_clear_drops: assert property ( // [R15]
        s_ff.pend && i_irq_clear && !alarm[0] && !alarm[1] |=> o_int_n)
        else $error("interrupt not released by clear");

    // ----------------------------------------------------------------------
    // channel one checks
    // ----------------------------------------------------------------------
    a_pin1_input_en: assert property ( // [R01] [R17]
        ch_en[1] && !i_bypass_sel_1 |=> !o_fan_tach_pin_1_oe)
        else $error("enabled tach pin one still driven");
    a_disabled_pin1: assert property ( // [R03] [R17]
        !ch_en[1] && !i_bypass_sel_1 |=> o_fan_tach_pin_1_oe == $past(i_gpio_oe[1]))
        else $error("disabled channel one altered pin");
    a_alarm1_raises: assert property ( // [R07] [R08] [R17]
        alarm[1] && !alarm[0] && !s_ff.pend
        |=> !o_int_n && o_interrupt_source_code == `FTS_ADDR_CTRL1)
        else $error("channel one alarm not raised");
    a_hold1_count: assert property ( // [R14] [R17]
        s_ff.pend && s_ff.src_ch && !i_irq_clear && ch_en[1]
        && !(i_reg_wr && i_reg_addr == `FTS_ADDR_CTRL1)
        |=> s_ff.cur[1] == $past(s_ff.cur[1]))
        else $error("channel one count moved while alarm pending");
    a_clear1_zeroes: assert property ( // [R15] [R17]
        clr_ch[1] && ch_en[1] |=> s_ff.cur[1] == `FTS_COUNT_RESET)
        else $error("channel one count not cleared with alarm");

endmodule : fts_top

// [testbench/fts_fan_model.sv]
// fan tachometer model: two pulses per revolution
`timescale 1ns/10ps
module fts_fan_model (
    input  wire logic        i_clk,
    input  wire logic        i_run,
    input  wire logic [15:0] i_rev,
    output logic             o_tach
);
    initial o_tach = 1'b0;
    // --------------------
    // pulse train
    // --------------------
    // slow rising edge bounces once; shorter than the filter span
    always begin
        @(posedge i_clk);
        if (i_run) begin
            o_tach <= 1'b1;
            repeat (2) @(posedge i_clk);
            o_tach <= 1'b0;
            @(posedge i_clk);
            o_tach <= 1'b1;
            repeat (i_rev / 4 - 3) @(posedge i_clk);
            o_tach <= 1'b0;
            repeat (i_rev / 2 - i_rev / 4 - 1) @(posedge i_clk);
        end
    end
endmodule : fts_fan_model

// [testbench/tb_top.sv]
// self-checking bench of the fan tachometer monitor
`timescale 1ns/10ps
`include "fts_regs.svh"
module tb_top;
    import fts_pkg::*;
    localparam int TDIV = 20;
    localparam int FILT = 4;
    logic        clk, rst_n, wr, rd, clr, bsel, bout;
    logic [7:0]  addr, wdata, rdata, src;
    logic        int_n;
    logic [1:0]  gout, goe, pin_i, pin_o, pin_oe, fan, run;
    logic [15:0] rev [2];
    int          errors, n_tests;

    // pin level: device drives when its output enable is set, else the fan
    assign pin_i[0] = pin_oe[0] ? pin_o[0] : fan[0];
    assign pin_i[1] = pin_oe[1] ? pin_o[1] : fan[1];

    fts_top #(.TICK_DIV(TDIV), .FILT_CYC(FILT)) u_fts_top (
        .i_mclk(clk), .i_reset_n(rst_n), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_irq_clear(clr), .o_int_n(int_n),
        .o_interrupt_source_code(src), .i_gpio_out(gout),
        .i_gpio_oe(goe), .i_bypass_sel_1(bsel), .i_bypass_out_1(bout),
        .i_fan_tach_pin_0(pin_i[0]), .o_fan_tach_pin_0(pin_o[0]),
        .o_fan_tach_pin_0_oe(pin_oe[0]), .i_fan_tach_pin_1(pin_i[1]),
        .o_fan_tach_pin_1(pin_o[1]), .o_fan_tach_pin_1_oe(pin_oe[1])
    );
    fts_fan_model u_fan0 (.i_clk(clk), .i_run(run[0]), .i_rev(rev[0]), .o_tach(fan[0]));
    fts_fan_model u_fan1 (.i_clk(clk), .i_run(run[1]), .i_rev(rev[1]), .o_tach(fan[1]));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // --------------------
    // helpers
    // --------------------
    function automatic logic [15:0] rev_of(input int t, input int d);
        return 16'(t * TDIV * (1 << d));
    endfunction : rev_of

    function automatic logic [7:0] exp_ctrl(input logic [7:0] v);
        return {v[7:6], 4'h0, v[1:0]};
    endfunction : exp_ctrl

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one count of slack: tick and prescale phase against the edges
    task automatic chk_near(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e && g !== e + 8'h01 && g !== e - 8'h01) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk_near

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic summarize();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // --------------------
    // scenarios
    // --------------------
    task automatic meas(input int ch, input int d);
        logic [7:0] b, v;
        int         t;
        b = ch ? `FTS_ADDR_CTRL1 : `FTS_ADDR_CTRL0;
        t = $urandom_range(12, 24);
        rev[ch] <= rev_of(t, d);
        run[ch] <= 1'b1;
        wr_reg(b + 8'h01, 8'h01);
        wr_reg(b, 8'h80 | 8'(d));
        rd_reg(b + 8'h02, v);
        chk("count before revolution", 8'h00, v);
        repeat (rev_of(t, d) * 5 / 2 + 40) @(posedge clk);
        rd_reg(b + 8'h02, v);
        chk_near("count", 8'(t), v);
        rev[ch] <= rev_of(t + 8, d);
        repeat (rev_of(t + 8, d) * 5 / 2 + 40) @(posedge clk);
        rd_reg(b + 8'h02, v);
        chk_near("count after speed change", 8'(t + 8), v);
        chk("int_n alarm off", 8'h01, int_n);
        run[ch] <= 1'b0;
        wr_reg(b, 8'h00);
    endtask : meas

    task automatic alarm(input int ch);
        logic [7:0] b, c1, c2;
        int         i;
        b = ch ? `FTS_ADDR_CTRL1 : `FTS_ADDR_CTRL0;
        rev[ch] <= rev_of(20, 0);
        run[ch] <= 1'b1;
        wr_reg(b + 8'h01, 8'h0A);
        wr_reg(b, 8'hC0);
        for (i = 0; i < 2000 && int_n !== 1'b0; i++) @(posedge clk);
        chk("int_n raised", 8'h00, int_n);
        chk("source code", b, src);
        rd_reg(b + 8'h02, c1);
        repeat (1000) @(posedge clk);
        rd_reg(b + 8'h02, c2);
        chk("held count", c1, c2);
        // alarm enable off first, else the count climbing back to the limit re-raises it
        wr_reg(b, 8'h80);
        chk("int_n pending", 8'h00, int_n);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1;
        chk("int_n cleared", 8'h01, int_n);
        rd_reg(b + 8'h02, c1);
        chk("count cleared", 8'h00, c1);
        run[ch] <= 1'b0;
        wr_reg(b, 8'h00);
    endtask : alarm

    initial begin
        logic [7:0] v, r;
        {wr, rd, clr, bsel, bout, run} = '0;
        {addr, wdata, gout, goe} = '0;
        rst_n  = 1'b0;
        rev[0] = 16'h0190;
        rev[1] = 16'h0190;
        void'($urandom(32'hE944));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 8'h30; a <= 8'h36; a++) begin
            rd_reg(8'(a), r);
            chk("reset value", 8'h00, r);
        end
        chk("int_n reset", 8'h01, int_n);
        v = 8'($urandom) & 8'h7F;
        wr_reg(`FTS_ADDR_CTRL1, v);
        rd_reg(`FTS_ADDR_CTRL1, r);
        chk("control", exp_ctrl(v), r);
        v = 8'($urandom);
        wr_reg(`FTS_ADDR_LIMIT0, v);
        rd_reg(`FTS_ADDR_LIMIT0, r);
        chk("limit", v, r);
        wr_reg(`FTS_ADDR_COUNT0, v);
        rd_reg(`FTS_ADDR_COUNT0, r);
        chk("count read only", 8'h00, r);
        rd_reg(8'h33, r);
        chk("unmapped", 8'h00, r);
        wr_reg(`FTS_ADDR_CTRL1, 8'h00);
        goe  <= 2'b11;
        gout <= 2'($urandom);
        wr_reg(`FTS_ADDR_LIMIT0, 8'h00);
        wr_reg(`FTS_ADDR_CTRL0, 8'h43);
        repeat (20) @(posedge clk);
        chk("pin0 oe disabled", 8'h01, pin_oe[0]);
        chk("pin0 out disabled", gout[0], pin_o[0]);
        chk("int_n disabled", 8'h01, int_n);
        wr_reg(`FTS_ADDR_CTRL0, 8'h80);
        repeat (3) @(posedge clk);
        chk("pin0 oe enabled", 8'h00, pin_oe[0]);
        wr_reg(`FTS_ADDR_CTRL0, 8'h00);
        goe <= 2'b00;
        for (int d = 0; d < 4; d++) meas(0, d);
        meas(1, $urandom_range(0, 2));
        wr_reg(`FTS_ADDR_CTRL0, 8'h80);
        repeat (255 * TDIV + 300) @(posedge clk);
        rd_reg(`FTS_ADDR_COUNT0, r);
        chk("stalled count", 8'hFF, r);
        repeat (300) @(posedge clk);
        rd_reg(`FTS_ADDR_COUNT0, r);
        chk("saturated count", 8'hFF, r);
        wr_reg(`FTS_ADDR_CTRL0, 8'h00);
        alarm(0);
        alarm(1);
        bsel <= 1'b1;
        bout <= 1'($urandom);
        wr_reg(`FTS_ADDR_CTRL1, 8'h80);
        repeat (3) @(posedge clk);
        chk("pin1 oe bypass", 8'h01, pin_oe[1]);
        chk("pin1 out bypass", bout, pin_o[1]);
        summarize();
    end

    initial begin
        repeat (95000) @(posedge clk);
        errors++;
        $display("unexpected run length: expected end seen limit");
        summarize();
    end
endmodule : tb_top
